// file: rtl/csr_status_regs.sv
`timescale 1ns/1ps
module csr_status_regs #(
    parameter int unsigned FLASH_CYCLES = csr_pkg::FLASH_CYCLES,
    parameter int unsigned BLINK_CYCLES = csr_pkg::BLINK_CYCLES
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    // Events from counting, gating and front panel logic
    input  wire logic        KNOB_CHANGE,
    input  wire logic        PERIOD_END,
    input  wire logic        SCAN_END,
    input  wire logic        SCAN_END_STOP,
    input  wire logic        GATE_MISSED,
    input  wire logic        RECALL_CORRUPT,
    input  wire logic        CMD_ERROR,
    input  wire logic        TRIGGERED,
    input  wire logic        INHIBITED,
    input  wire logic        COUNTING,
    input  wire logic        B_PRESET,
    input  wire logic [31:0] COUNT_A,
    input  wire logic [31:0] COUNT_B,
    // Command reads
    input  wire logic        RD_REQ,
    input  wire logic [1:0]  RD_SEL,
    input  wire logic        RD_BIT_EN,
    input  wire logic [2:0]  RD_BIT,
    output logic             RD_VALID,
    output logic [31:0]      RD_DATA,
    // Serial poll
    input  wire logic        POLL_REQ,
    input  wire logic        SRQ_ACTIVE,
    output logic             POLL_VALID,
    output logic [7:0]       POLL_DATA,
    // Received characters and line discard
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_CHAR,
    input  wire logic        BUF_CLEAR,
    output logic             DISCARD,
    output logic             ERR_LED,
    // History window
    input  wire logic        VIEW_OPEN,
    input  wire logic        SCROLL_BACK,
    input  wire logic        SCROLL_FWD,
    output logic [7:0]       VIEW_CHAR,
    output logic [7:0]       VIEW_OFFSET,
    output logic [7:0]       HIST_COUNT
);

    ////////////////////////////////////////////////////////////////////////////
    // Status events and clear masks

    logic [7:0]  pri;
    logic [1:0]  sec;
    logic [7:0]  pri_set;
    logic [1:0]  sec_set;
    logic [7:0]  pri_clr;
    logic [1:0]  sec_clr;
    logic [7:0]  bit_mask;
    logic        rd_pri;
    logic        rd_sec;
    logic        overrun;

    // Either counter at or past the limit
    assign overrun = (COUNT_A >= csr_pkg::OVERRUN_LIMIT) ||
                     (COUNT_B >= csr_pkg::OVERRUN_LIMIT);

    assign rd_pri   = RD_REQ && (RD_SEL == csr_pkg::CSR_SEL_PRIMARY);
    assign rd_sec   = RD_REQ && (RD_SEL == csr_pkg::CSR_SEL_SECONDARY);
    assign bit_mask = 8'h01 << RD_BIT;

    // Sticky sources of the primary byte; bit 6 is never stored
    always_comb begin
        pri_set = 8'h00;
        pri_set[csr_pkg::PRI_KNOB]    = KNOB_CHANGE;
        pri_set[csr_pkg::PRI_READY]   = PERIOD_END;
        pri_set[csr_pkg::PRI_SCAN]    = SCAN_END && SCAN_END_STOP;
        pri_set[csr_pkg::PRI_OVERRUN] = overrun;
        pri_set[csr_pkg::PRI_RATE]    = GATE_MISSED;
        pri_set[csr_pkg::PRI_RECALL]  = RECALL_CORRUPT;
        pri_set[csr_pkg::PRI_CMDERR]  = CMD_ERROR;
    end

    // Sticky sources of the secondary byte; counting is sampled live instead
    always_comb begin
        sec_set = 2'h0;
        sec_set[csr_pkg::SEC_TRIG]    = TRIGGERED;
        sec_set[csr_pkg::SEC_INHIBIT] = INHIBITED;
    end

    // A whole-byte read clears its whole byte, a bit read clears one bit; secondary bit indices above 1 clear nothing
    always_comb begin
        pri_clr = 8'h00;
        sec_clr = 2'h0;
        if (rd_pri) begin
            pri_clr = RD_BIT_EN ? bit_mask : 8'hff;
        end
        if (rd_sec) begin
            sec_clr = RD_BIT_EN ? bit_mask[1:0] : 2'h3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status registers

    // Set wins over clear so an event during its own read is kept
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            pri <= csr_pkg::PRI_RESET;
        end else begin
            pri <= (pri & ~pri_clr) | pri_set;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            sec <= csr_pkg::SEC_RESET;
        end else begin
            sec <= (sec & ~sec_clr) | sec_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answers

    logic [7:0]  pri_view;
    logic [2:0]  sec_view;
    logic [7:0]  sec_wide;
    logic [31:0] next_rd_data;

    // Bit 6 is masked off for command reads
    assign pri_view = pri & ~(8'h01 << csr_pkg::PRI_SRQ);
    // Counting bit reflects the counters at the instant of the read
    assign sec_view = {COUNTING, sec};
    // Padded to a byte so a bit index never selects outside the vector
    assign sec_wide = {5'h00, sec_view};

    always_comb begin
        next_rd_data = 32'h0000_0000;
        unique case (RD_SEL)
            csr_pkg::CSR_SEL_PRIMARY: begin
                if (RD_BIT_EN) begin
                    next_rd_data = {31'h0, pri_view[RD_BIT]};
                end else begin
                    next_rd_data = {24'h0, pri_view};
                end
            end
            csr_pkg::CSR_SEL_SECONDARY: begin
                // Bit indices above 2 answer zero
                if (RD_BIT_EN) begin
                    next_rd_data = {31'h0, sec_wide[RD_BIT]};
                end else begin
                    next_rd_data = {29'h0, sec_view};
                end
            end
            csr_pkg::CSR_SEL_LIVE_A: begin
                next_rd_data = COUNTING ? COUNT_A : 32'h0000_0000;
            end
            csr_pkg::CSR_SEL_LIVE_B: begin
                if (B_PRESET) begin
                    next_rd_data = csr_pkg::PRESET_ANSWER;
                end else begin
                    next_rd_data = COUNTING ? COUNT_B : 32'h0000_0000;
                end
            end
        endcase
    end

    // Answer one edge after the request
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            RD_VALID <= 1'b0;
            RD_DATA  <= 32'h0000_0000;
        end else begin
            RD_VALID <= RD_REQ;
            if (RD_REQ) begin
                RD_DATA <= next_rd_data;
            end
        end
    end

    // Serial poll shows the service request bit and leaves the byte intact
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            POLL_VALID <= 1'b0;
            POLL_DATA  <= 8'h00;
        end else begin
            POLL_VALID <= POLL_REQ;
            if (POLL_REQ) begin
                POLL_DATA <= pri_view | ({7'h0, SRQ_ACTIVE} << csr_pkg::PRI_SRQ);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error handling: line discard and indicator flash

    logic [31:0] flash_cnt;
    logic [31:0] blink_cnt;

    // Drop characters until the carriage return that ends the faulty line
    always_ff @(posedge REF_CLK) begin
        if (!NRST || BUF_CLEAR) begin
            DISCARD <= 1'b0;
        end else if (CMD_ERROR) begin
            DISCARD <= 1'b1;
        end else if (RX_VALID && RX_CHAR == csr_pkg::CHAR_CR) begin
            DISCARD <= 1'b0;
        end
    end

    // A new error restarts the flash window
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            flash_cnt <= 32'h0000_0000;
        end else if (CMD_ERROR) begin
            flash_cnt <= FLASH_CYCLES;
        end else if (flash_cnt != 32'h0000_0000) begin
            flash_cnt <= flash_cnt - 32'h0000_0001;
        end
    end

    // Blink divider toggles the indicator while the window is open
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            blink_cnt <= 32'h0000_0000;
            ERR_LED   <= 1'b0;
        end else if (flash_cnt == 32'h0000_0000) begin
            blink_cnt <= 32'h0000_0000;
            ERR_LED   <= 1'b0;
        end else if (blink_cnt == 32'h0000_0000) begin
            blink_cnt <= BLINK_CYCLES - 1;
            ERR_LED   <= ~ERR_LED;
        end else begin
            blink_cnt <= blink_cnt - 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received-character history

    logic [7:0] hist_mem [csr_pkg::HIST_DEPTH];
    logic [7:0] wr_ptr;
    logic [7:0] rd_idx;
    logic [8:0] back;

    // Oldest character is overwritten once the ring is full
    always_ff @(posedge REF_CLK) begin
        if (RX_VALID) begin
            hist_mem[wr_ptr] <= RX_CHAR;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST || BUF_CLEAR) begin
            wr_ptr     <= 8'h00;
            HIST_COUNT <= 8'h00;
        end else if (RX_VALID) begin
            wr_ptr <= (wr_ptr == 8'(csr_pkg::HIST_DEPTH - 1)) ? 8'h00 : wr_ptr + 8'h01;
            if (HIST_COUNT != 8'(csr_pkg::HIST_DEPTH)) begin
                HIST_COUNT <= HIST_COUNT + 8'h01;
            end
        end
    end

    // Offset back from the newest; arrival or opening snaps to the newest
    always_ff @(posedge REF_CLK) begin
        if (!NRST || BUF_CLEAR) begin
            VIEW_OFFSET <= 8'h00;
        end else if (RX_VALID || VIEW_OPEN) begin
            VIEW_OFFSET <= 8'h00;
        end else if (SCROLL_BACK && (VIEW_OFFSET + 8'h01 < HIST_COUNT)) begin
            VIEW_OFFSET <= VIEW_OFFSET + 8'h01;
        end else if (SCROLL_FWD && VIEW_OFFSET != 8'h00) begin
            VIEW_OFFSET <= VIEW_OFFSET - 8'h01;
        end
    end

    // Ring index of the viewed character, wrapped without a divider
    assign back   = {1'b0, wr_ptr} + 9'(csr_pkg::HIST_DEPTH) - 9'h001 - {1'b0, VIEW_OFFSET};
    assign rd_idx = (back >= 9'(csr_pkg::HIST_DEPTH)) ?
                    8'(back - 9'(csr_pkg::HIST_DEPTH)) : back[7:0];

    // Empty history shows zero rather than stale memory
    always_ff @(posedge REF_CLK) begin
        if (!NRST || BUF_CLEAR || HIST_COUNT == 8'h00) begin
            VIEW_CHAR <= 8'h00;
        end else begin
            VIEW_CHAR <= hist_mem[rd_idx];
        end
    end

endmodule

// file: include/csr_pkg.sv
package csr_pkg;

    // Primary status bit positions
    localparam int unsigned PRI_KNOB     = 0;
    localparam int unsigned PRI_READY    = 1;
    localparam int unsigned PRI_SCAN     = 2;
    localparam int unsigned PRI_OVERRUN  = 3;
    localparam int unsigned PRI_RATE     = 4;
    localparam int unsigned PRI_RECALL   = 5;
    localparam int unsigned PRI_SRQ      = 6;
    localparam int unsigned PRI_CMDERR   = 7;

    // Secondary status bit positions
    localparam int unsigned SEC_TRIG     = 0;
    localparam int unsigned SEC_INHIBIT  = 1;
    localparam int unsigned SEC_COUNTING = 2;

    // Widths and values after reset
    localparam int unsigned PRI_W        = 8;
    localparam int unsigned SEC_W        = 3;
    localparam int unsigned CNT_W        = 32;
    localparam logic [7:0]  PRI_RESET    = 8'h00;
    localparam logic [1:0]  SEC_RESET    = 2'h0;

    // Overrun limit, ten to the ninth minus one
    localparam logic [CNT_W-1:0] OVERRUN_LIMIT = 32'h3b9a_c9ff;
    // Live answer of counter B while it is a preset counter
    localparam logic [CNT_W-1:0] PRESET_ANSWER = 32'hffff_ffff;

    // Read selector codes
    typedef enum logic [1:0] {
        CSR_SEL_PRIMARY   = 2'b00,
        CSR_SEL_SECONDARY = 2'b01,
        CSR_SEL_LIVE_A    = 2'b10,
        CSR_SEL_LIVE_B    = 2'b11
    } csr_sel_t;

    // Received-character history
    localparam int unsigned HIST_DEPTH   = 254;
    localparam int unsigned HIST_AW      = 8;
    localparam logic [7:0]  CHAR_CR      = 8'h0d;

    // Error indicator flash timing
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned FLASH_MS     = 100;
    localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
    localparam int unsigned BLINK_MS     = 25;
    localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

endpackage

// file: verification/csr_status_properties.sv
`timescale 1ns/1ps
module csr_status_chk (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        NRST,
    // Events and levels
    input wire logic        PERIOD_END,
    input wire logic        CMD_ERROR,
    input wire logic        SRQ_ACTIVE,
    input wire logic        COUNTING,
    input wire logic        B_PRESET,
    input wire logic        RX_VALID,
    input wire logic        BUF_CLEAR,
    // Reads and poll
    input wire logic        RD_REQ,
    input wire logic [1:0]  RD_SEL,
    input wire logic        RD_BIT_EN,
    input wire logic        RD_VALID,
    input wire logic [31:0] RD_DATA,
    input wire logic        POLL_REQ,
    input wire logic        POLL_VALID,
    input wire logic [7:0]  POLL_DATA,
    // Line and history
    input wire logic        DISCARD,
    input wire logic [7:0]  HIST_COUNT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////
    // Whole-register reads of the primary and secondary selectors
    logic rd_pri;
    logic rd_sec;
    assign rd_pri = RD_REQ && !RD_BIT_EN && RD_SEL == 2'h0;
    assign rd_sec = RD_REQ && !RD_BIT_EN && RD_SEL == 2'h1;

    // Answer timing and content
    a_read_answered: assert property (RD_REQ |=> RD_VALID)
        else $error("read not answered");
    a_pri_bit6_low: assert property (rd_pri |=> RD_DATA[31:8] == 24'h0 && !RD_DATA[6])
        else $error("primary read shows bit 6");
    // Event during a clearing read, an idle cycle, then the next full read
    a_event_kept: assert property (rd_pri && PERIOD_END ##1 !RD_REQ ##1 rd_pri
        |=> RD_DATA[1])
        else $error("event lost in clearing read");
    a_sec_live_bit: assert property (rd_sec |=> RD_DATA[31:3] == 29'h0
        && RD_DATA[2] == $past(COUNTING))
        else $error("secondary counting bit wrong");
    a_live_idle_zero: assert property (RD_REQ && !RD_BIT_EN && RD_SEL == 2'h2
        && !COUNTING |=> RD_DATA == 32'h0)
        else $error("idle live read not zero");
    a_live_preset: assert property (RD_REQ && !RD_BIT_EN && RD_SEL == 2'h3
        && B_PRESET |=> RD_DATA == 32'hffff_ffff)
        else $error("preset live read not minus one");
    a_poll_srq_bit: assert property (POLL_REQ |=> POLL_VALID
        && POLL_DATA[6] == $past(SRQ_ACTIVE))
        else $error("poll bit 6 wrong");
    a_discard_start: assert property (CMD_ERROR |=> DISCARD)
        else $error("discard not started");
    a_hist_cleared: assert property (BUF_CLEAR && !RX_VALID |=> HIST_COUNT == 8'h0)
        else $error("history not emptied");

    // Main scenarios reached
    cover property (rd_pri ##1 RD_DATA[7]);
    cover property (CMD_ERROR ##1 DISCARD);
    cover property (POLL_REQ && SRQ_ACTIVE);
endmodule
////////////////////////////////////////
bind csr_status_regs csr_status_chk csr_status_chk_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .PERIOD_END(PERIOD_END), .CMD_ERROR(CMD_ERROR),
    .SRQ_ACTIVE(SRQ_ACTIVE), .COUNTING(COUNTING), .B_PRESET(B_PRESET),
    .RX_VALID(RX_VALID), .BUF_CLEAR(BUF_CLEAR), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL),
    .RD_BIT_EN(RD_BIT_EN), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .POLL_REQ(POLL_REQ), .POLL_VALID(POLL_VALID), .POLL_DATA(POLL_DATA),
    .DISCARD(DISCARD), .HIST_COUNT(HIST_COUNT)
);

// file: verification/csr_host_model.sv
`timescale 1ns/1ps
module csr_host_model (
    // Clock
    input wire logic        REF_CLK,
    // Read command side
    output logic            RD_REQ,
    output logic [1:0]      RD_SEL,
    output logic            RD_BIT_EN,
    output logic [2:0]      RD_BIT,
    input wire logic        RD_VALID,
    input wire logic [31:0] RD_DATA,
    // Serial poll side
    output logic            POLL_REQ,
    input wire logic        POLL_VALID,
    input wire logic [7:0]  POLL_DATA
);
    // Idle from time zero
    initial begin
        RD_REQ = 1'b0;
        RD_SEL = 2'h0;
        RD_BIT_EN = 1'b0;
        RD_BIT = 3'h0;
        POLL_REQ = 1'b0;
    end

    // One read; a missing answer comes back unknown so any compare fails
    task automatic rd(input logic [1:0] s, input logic be, input logic [2:0] b,
                      output logic [31:0] d);
        @(negedge REF_CLK);
        RD_REQ = 1'b1;
        RD_SEL = s;
        RD_BIT_EN = be;
        RD_BIT = b;
        @(negedge REF_CLK);
        RD_REQ = 1'b0;
        RD_SEL = ~s; // Released selector must not keep its old value
        RD_BIT = ~b;
        d = (RD_VALID === 1'b1) ? RD_DATA : 'x;
    endtask

    // One serial poll
    task automatic poll(output logic [7:0] d);
        @(negedge REF_CLK);
        POLL_REQ = 1'b1;
        @(negedge REF_CLK);
        POLL_REQ = 1'b0;
        d = (POLL_VALID === 1'b1) ? POLL_DATA : 'x;
    endtask
endmodule

// file: verification/csr_status_regs_tb_top.sv
`timescale 1ns/1ps
module csr_status_regs_tb_top;
    // Bench signals
    logic        ref_clk, nrst, stop, counting, b_preset, srq, rx_valid;
    logic [11:0] ev;
    logic [7:0]  rx_char, poll_data, view_char, view_offset, hist_count;
    logic [31:0] count_a, count_b, rd_data;
    logic [1:0]  rd_sel;
    logic [2:0]  rd_bit;
    logic        rd_req, rd_bit_en, rd_valid, poll_req, poll_valid, discard, err_led;
    logic [7:0]  p;
    int          n_mismatch, checked, i;
    localparam int PB[6] = '{0, 1, 2, 4, 5, 7};

    // Short flash keeps the run brief
    csr_status_regs #(.FLASH_CYCLES(40), .BLINK_CYCLES(4)) csr_status_regs_i (
        .REF_CLK(ref_clk), .NRST(nrst), .KNOB_CHANGE(ev[0]), .PERIOD_END(ev[1]),
        .SCAN_END(ev[2]), .SCAN_END_STOP(stop), .GATE_MISSED(ev[4]),
        .RECALL_CORRUPT(ev[5]), .CMD_ERROR(ev[7]), .TRIGGERED(ev[3]), .INHIBITED(ev[6]),
        .COUNTING(counting), .B_PRESET(b_preset), .COUNT_A(count_a), .COUNT_B(count_b),
        .RD_REQ(rd_req), .RD_SEL(rd_sel), .RD_BIT_EN(rd_bit_en), .RD_BIT(rd_bit),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .POLL_REQ(poll_req), .SRQ_ACTIVE(srq),
        .POLL_VALID(poll_valid), .POLL_DATA(poll_data), .RX_VALID(rx_valid),
        .RX_CHAR(rx_char), .BUF_CLEAR(ev[11]), .DISCARD(discard), .ERR_LED(err_led),
        .VIEW_OPEN(ev[8]), .SCROLL_BACK(ev[9]), .SCROLL_FWD(ev[10]),
        .VIEW_CHAR(view_char), .VIEW_OFFSET(view_offset), .HIST_COUNT(hist_count));
    csr_host_model csr_host_model_i (
        .REF_CLK(ref_clk), .RD_REQ(rd_req), .RD_SEL(rd_sel), .RD_BIT_EN(rd_bit_en),
        .RD_BIT(rd_bit), .RD_VALID(rd_valid), .RD_DATA(rd_data), .POLL_REQ(poll_req),
        .POLL_VALID(poll_valid), .POLL_DATA(poll_data));
    ////////////////////////////////////////
    // Clock, 5 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Read through the host and compare
    task automatic rc(input logic [1:0] s, input logic be, input logic [2:0] b,
                      input logic [31:0] e);
        logic [31:0] d;
        csr_host_model_i.rd(s, be, b, d);
        chk(d, e);
    endtask

    // One-cycle strobes, raised and dropped on falling edges with no gap cycle after
    task automatic pulse(input logic [11:0] m);
        @(negedge ref_clk);
        ev = m;
        @(negedge ref_clk);
        ev = 12'h0;
    endtask

    task automatic send(input logic [7:0] c);
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_char = c;
        @(negedge ref_clk);
        rx_valid = 1'b0;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {nrst, stop, counting, b_preset, srq, rx_valid} = 6'h0;
        ev = 12'h0;
        rx_char = 8'h0;
        count_a = 32'h0;
        count_b = 32'h3b9a_c9fe;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        rc(2'h0, 1'b0, 3'h0, 32'h0);
        stop = 1'b1;
        foreach (PB[k]) begin
            pulse(12'h1 << PB[k]);
            rc(2'h0, 1'b0, 3'h0, 32'h1 << PB[k]);
            rc(2'h0, 1'b0, 3'h0, 32'h0);
        end
        count_a = 32'h3b9a_c9ff;
        @(negedge ref_clk);
        count_a = 32'h0;
        rc(2'h0, 1'b0, 3'h0, 32'h8);
        // Counter B above the limit sets the same bit
        count_b = 32'h3b9a_ca00;
        @(negedge ref_clk);
        count_b = 32'h0;
        rc(2'h0, 1'b0, 3'h0, 32'h8);
        stop = 1'b0;
        pulse(12'h4);
        rc(2'h0, 1'b0, 3'h0, 32'h0);
        srq = 1'b1;
        pulse(12'h1);
        csr_host_model_i.poll(p);
        chk(p, 32'h41);
        rc(2'h0, 1'b0, 3'h0, 32'h1);
        srq = 1'b0;
        pulse(12'h3);
        rc(2'h0, 1'b1, 3'h1, 32'h1);
        rc(2'h0, 1'b0, 3'h0, 32'h1);
        fork
            rc(2'h0, 1'b0, 3'h0, 32'h0);
            pulse(12'h2);
        join
        rc(2'h0, 1'b0, 3'h0, 32'h2);
        counting = 1'b1;
        pulse(12'h48);
        rc(2'h1, 1'b1, 3'h0, 32'h1);
        rc(2'h1, 1'b0, 3'h0, 32'h6);
        counting = 1'b0;
        rc(2'h1, 1'b0, 3'h0, 32'h0);
        // Live counter answers
        counting = 1'b1;
        count_a = 32'h0012_3456;
        count_b = 32'h0000_0005;
        rc(2'h2, 1'b0, 3'h0, 32'h0012_3456);
        rc(2'h3, 1'b0, 3'h0, 32'h5);
        b_preset = 1'b1;
        rc(2'h3, 1'b0, 3'h0, 32'hffff_ffff);
        counting = 1'b0;
        rc(2'h2, 1'b0, 3'h0, 32'h0);
        // Earlier error left discard on; clearing buffers first lets the check bite
        pulse(12'h800);
        chk(discard, 32'h0);
        pulse(12'h80);
        chk(discard, 32'h1);
        for (i = 0; i < 8 && err_led !== 1'b1; i++) @(negedge ref_clk);
        chk(err_led, 32'h1);
        send(8'h61);
        chk(discard, 32'h1);
        send(8'h0d);
        chk(discard, 32'h0);
        @(negedge ref_clk);
        chk(hist_count, 32'h2);
        chk(view_char, 32'h0d);
        pulse(12'h200);
        @(negedge ref_clk);
        chk(view_offset, 32'h1);
        chk(view_char, 32'h61);
        pulse(12'h400);
        chk(view_offset, 32'h0);
        pulse(12'h200);
        pulse(12'h100);
        chk(view_offset, 32'h0);
        pulse(12'h200);
        send(8'h62);
        chk(view_offset, 32'h0);
        for (i = 0; i < 300; i++) send(i[7:0]);
        chk(hist_count, 32'hfe);
        chk(err_led, 32'h0);
        pulse(12'h200);
        chk(view_offset, 32'h1);
        pulse(12'h800);
        chk(hist_count, 32'h0);
        chk(view_offset, 32'h0);
        chk(view_char, 32'h0);
        wrap_up();
    end
endmodule
